// ===== sjd_pkg.sv
// Purpose: shared constants and carriers for speed jump, display scaling, regen select
// Assumes: speeds in 0.1 r/min steps internally, display values unsigned
// Notes:   register offsets index 32-bit words on the plain register port
package sjd_pkg;
    localparam logic [15:0] SJD_DISABLED   = 16'h270F; // 9999
    localparam logic [15:0] SJD_SPEED_MAX  = 16'h0E10; // 3600 r/min
    localparam logic [15:0] SJD_REF_RESET  = 16'h05DC; // 1500 r/min
    localparam logic [15:0] SJD_MACH_MAX   = 16'h270E; // 9998
    localparam logic [15:0] SJD_DISP_LIMIT = 16'h270F; // 9999
    localparam logic [15:0] SJD_DASH       = 16'hFFFF; // dash pattern code
    localparam logic [6:0]  SJD_DUTY_SMALL = 7'h02;
    localparam logic [6:0]  SJD_DUTY_LARGE = 7'h00;
    localparam logic [6:0]  SJD_DUTY_MAX1  = 7'h0F;
    localparam logic [6:0]  SJD_DUTY_MAX2  = 7'h1E;
    localparam logic [4:0]  SJD_FUNC_PERMIT = 5'h0A;
    localparam logic [4:0]  SJD_FUNC_DIP    = 5'h0B;
    // register offsets (word index)
    localparam logic [5:0] SJD_A_JUMP1P = 6'h00;
    localparam logic [5:0] SJD_A_JUMP1E = 6'h01;
    localparam logic [5:0] SJD_A_JUMP2P = 6'h02;
    localparam logic [5:0] SJD_A_JUMP2E = 6'h03;
    localparam logic [5:0] SJD_A_JUMP3P = 6'h04;
    localparam logic [5:0] SJD_A_JUMP3E = 6'h05;
    localparam logic [5:0] SJD_A_MACH   = 6'h06;
    localparam logic [5:0] SJD_A_POLES  = 6'h07;
    localparam logic [5:0] SJD_A_REFSPD = 6'h08;
    localparam logic [5:0] SJD_A_REGEN  = 6'h09;
    localparam logic [5:0] SJD_A_DUTY   = 6'h0A;
    localparam logic [5:0] SJD_A_INMAP  = 6'h0B;
    localparam logic [5:0] SJD_A_STATUS = 6'h0C;
    localparam logic [5:0] SJD_A_IRQST  = 6'h0D;
    localparam logic [5:0] SJD_A_IRQMSK = 6'h0E;
    localparam logic [5:0] SJD_A_DISP   = 6'h0F;
    localparam logic [5:0] SJD_A_TARGET = 6'h10;
    localparam int SJD_NIRQ = 3;
    localparam logic [2:0] SJD_IRQ_RESET = 3'h0;
    typedef enum logic [1:0]
    {
        SJD_UNIT_RPM  = 2'b00,
        SJD_UNIT_HZ   = 2'b01,
        SJD_UNIT_MACH = 2'b10
    } sjd_unit_t;
    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } sjd_bus_t;
    typedef struct packed
    {
        logic [15:0] point;
        logic [15:0] edge_v;
    } sjd_band_t;
endpackage

// ===== sjd_core.sv
// Purpose: speed jump bands, display scaling/units and regen brake mode selection
// Assumes: one clock, synchronous reset, command speed in 0.1 r/min steps
// Notes:   ramping flag supplied by the ramp generator on the same clock
//
// Summary of operation
// - mode 0 uses fixed built-in duty
// - mode 1 limits duty to programmed value
// - mode 2 shuts output without run permit
// - in mode 2, dip input holds pre-dip mode if retained
// - duty setting void on large ratings
// - three bands, 9999 disables, reset 9999
// - steady command in band runs at point
// - ramping speed passes bands unclamped
// - overlapping band write rejected with error
// - machine speed scaled from reference speed
// - display frequency from display pole count
// - units chosen from display settings combination
// - over 9999 shows dash pattern
// - speed settings rounded to 1 r/min
// - frequency setting runs at synchronous speed
`timescale 1ns/10ps
module sjd_core #(
    parameter logic RATING_SMALLEST = 1'b0, // 1.5K class
    parameter logic RATING_SMALL    = 1'b1, // 5.5K or less
    parameter logic RATING_LARGE    = 1'b0  // 18.5K or more
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // register port
    input  wire logic [5:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // speed path
    input  wire logic [15:0] speed_cmd,
    input  wire logic        ramping,
    input  wire logic [15:0] running_speed,
    output logic [15:0]      target_speed,
    // input terminals from converter
    input  wire logic [7:0]  input_terms,
    // drive controls
    input  wire logic        retain_mode_on_dip,
    output logic             output_shutoff,
    output logic             hold_mode,
    output logic [6:0]       brake_duty_limit,
    // panel
    output logic [15:0]      panel_value,
    output logic [1:0]       speed_unit,
    output logic [1:0]       setting_unit,
    output logic             write_error,
    output logic             irq
);
    typedef struct packed
    {
        logic [7:0]          term_s1;
        logic [7:0]          term_s2;
        sjd_pkg::sjd_band_t [2:0] band;
        logic [15:0]         mach;
        logic [3:0]          poles;
        logic [15:0]         refspd;
        logic [1:0]          regen;
        logic [6:0]          duty;
        logic [2:0]          permit_sel;
        logic [2:0]          dip_sel;
        logic [2:0]          irq_st;
        logic [2:0]          irq_msk;
        logic                werr;
        logic [15:0]         target;
        logic [15:0]         disp;
        logic [31:0]         rdata;
        logic                permit_prev;
    } sjd_state_t;

    sjd_state_t st;
    sjd_state_t next_st;

    logic [15:0] cand;
    logic [15:0] lo [3];
    logic [15:0] hi [3];
    logic [2:0]  en;
    logic [15:0] c_lo [3];
    logic [15:0] c_hi [3];
    logic [2:0]  c_en;
    logic        overlap;
    logic        permit;
    logic        dip;
    logic [15:0] sel_tgt;
    logic [31:0] prod;
    logic [31:0] scaled;
    logic [15:0] rpm;
    logic [2:0]  ev;
    sjd_pkg::sjd_band_t [2:0] wband;

    function automatic logic [15:0] round_rpm(input logic [15:0] v);
        logic [15:0] r;
        r = 16'((32'(v) + 32'd5) / 32'd10 * 32'd10); // whole r/min, round half up
        return r;
    endfunction

    always_comb
    begin
        next_st = st;
        next_st.term_s1 = input_terms;
        next_st.term_s2 = st.term_s1;
        wband = st.band;
        ev = 3'h0;
        // candidate band set for a jump write
        if (reg_wr && reg_addr <= sjd_pkg::SJD_A_JUMP3E)
        begin
            if (reg_addr[0])
                wband[reg_addr[2:1]].edge_v = reg_wdata[15:0];
            else
                wband[reg_addr[2:1]].point = reg_wdata[15:0];
        end
        for (int i = 0; i < 3; i++)
        begin
            lo[i] = (st.band[i].point < st.band[i].edge_v) ? st.band[i].point : st.band[i].edge_v;
            hi[i] = (st.band[i].point < st.band[i].edge_v) ? st.band[i].edge_v : st.band[i].point;
            en[i] = (st.band[i].point != sjd_pkg::SJD_DISABLED) &&
                    (st.band[i].edge_v != sjd_pkg::SJD_DISABLED);
            c_lo[i] = (wband[i].point < wband[i].edge_v) ? wband[i].point : wband[i].edge_v;
            c_hi[i] = (wband[i].point < wband[i].edge_v) ? wband[i].edge_v : wband[i].point;
            c_en[i] = (wband[i].point != sjd_pkg::SJD_DISABLED) &&
                      (wband[i].edge_v != sjd_pkg::SJD_DISABLED);
        end
        overlap = 1'b0;
        for (int i = 0; i < 3; i++)
            for (int j = i + 1; j < 3; j++)
                if (c_en[i] && c_en[j] && c_lo[i] <= c_hi[j] && c_lo[j] <= c_hi[i])
                    overlap = 1'b1;
        // jump applies to target only; running speed is never clamped
        cand = speed_cmd;
        sel_tgt = speed_cmd;
        for (int i = 0; i < 3; i++)
            if (en[i] && cand >= lo[i] * 16'd10 && cand <= hi[i] * 16'd10)
                sel_tgt = 16'(st.band[i].point * 16'd10);
        if (!ramping)
            next_st.target = sel_tgt;
        else
            next_st.target = speed_cmd;

        // register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                sjd_pkg::SJD_A_JUMP1P, sjd_pkg::SJD_A_JUMP1E,
                sjd_pkg::SJD_A_JUMP2P, sjd_pkg::SJD_A_JUMP2E,
                sjd_pkg::SJD_A_JUMP3P, sjd_pkg::SJD_A_JUMP3E:
                begin
                    if (overlap || (reg_wdata[15:0] > sjd_pkg::SJD_SPEED_MAX &&
                        reg_wdata[15:0] != sjd_pkg::SJD_DISABLED))
                    begin
                        next_st.werr = 1'b1;
                        ev[0] = 1'b1;
                    end
                    else
                    begin
                        next_st.band = wband;
                        next_st.werr = 1'b0;
                    end
                end
                sjd_pkg::SJD_A_MACH:
                    if (reg_wdata[15:0] <= sjd_pkg::SJD_MACH_MAX)
                        next_st.mach = reg_wdata[15:0];
                sjd_pkg::SJD_A_POLES:
                    if (reg_wdata[3:0] <= 4'hA && !reg_wdata[0] && reg_wdata[31:4] == 28'h0)
                        next_st.poles = reg_wdata[3:0];
                sjd_pkg::SJD_A_REFSPD:
                    if (reg_wdata[15:0] >= 16'h0001 && reg_wdata[15:0] <= sjd_pkg::SJD_SPEED_MAX)
                        next_st.refspd = reg_wdata[15:0];
                sjd_pkg::SJD_A_REGEN:
                    if (reg_wdata[1:0] != 2'h3)
                        next_st.regen = reg_wdata[1:0];
                sjd_pkg::SJD_A_DUTY:
                    if (reg_wdata[6:0] <= (RATING_SMALLEST ? sjd_pkg::SJD_DUTY_MAX1
                                                           : sjd_pkg::SJD_DUTY_MAX2))
                        next_st.duty = reg_wdata[6:0];
                sjd_pkg::SJD_A_INMAP:
                begin
                    next_st.permit_sel = reg_wdata[2:0];
                    next_st.dip_sel = reg_wdata[10:8];
                end
                sjd_pkg::SJD_A_IRQMSK:
                    next_st.irq_msk = reg_wdata[2:0];
                default:
                    next_st = next_st;
            endcase
        end

        // converter inputs, function codes mapped to terminals by software
        permit = st.term_s2[st.permit_sel];
        dip = st.term_s2[st.dip_sel];
        next_st.permit_prev = permit;
        if (st.regen == 2'h2 && st.permit_prev && !permit)
            ev[1] = 1'b1;
        if (st.regen == 2'h2 && dip)
            ev[2] = 1'b1;

        // display scaling: 0.1 r/min in, displayed units out
        rpm = 16'((32'(running_speed) + 32'd5) / 32'd10);
        prod = 32'h0;
        scaled = 32'(rpm);
        if (st.mach != 16'h0)
        begin
            prod = 32'(rpm) * 32'(st.mach);
            scaled = prod / 32'(st.refspd);
        end
        else if (st.poles != 4'h0)
            scaled = 32'(rpm) * 32'(st.poles) / 32'd120;
        if (scaled > 32'(sjd_pkg::SJD_DISP_LIMIT))
            next_st.disp = sjd_pkg::SJD_DASH;
        else
            next_st.disp = scaled[15:0];

        // sticky status: read clears, a new event in the same cycle wins
        if (reg_rd && reg_addr == sjd_pkg::SJD_A_IRQST)
            next_st.irq_st = ev;
        else
            next_st.irq_st = st.irq_st | ev;

        next_st.rdata = 32'h0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                sjd_pkg::SJD_A_JUMP1P: next_st.rdata = {16'h0, st.band[0].point};
                sjd_pkg::SJD_A_JUMP1E: next_st.rdata = {16'h0, st.band[0].edge_v};
                sjd_pkg::SJD_A_JUMP2P: next_st.rdata = {16'h0, st.band[1].point};
                sjd_pkg::SJD_A_JUMP2E: next_st.rdata = {16'h0, st.band[1].edge_v};
                sjd_pkg::SJD_A_JUMP3P: next_st.rdata = {16'h0, st.band[2].point};
                sjd_pkg::SJD_A_JUMP3E: next_st.rdata = {16'h0, st.band[2].edge_v};
                sjd_pkg::SJD_A_MACH:   next_st.rdata = {16'h0, st.mach};
                sjd_pkg::SJD_A_POLES:  next_st.rdata = {28'h0, st.poles};
                sjd_pkg::SJD_A_REFSPD: next_st.rdata = {16'h0, st.refspd};
                sjd_pkg::SJD_A_REGEN:  next_st.rdata = {30'h0, st.regen};
                sjd_pkg::SJD_A_DUTY:   next_st.rdata = {25'h0, st.duty};
                sjd_pkg::SJD_A_INMAP:  next_st.rdata = {21'h0, st.dip_sel, 5'h0, st.permit_sel};
                sjd_pkg::SJD_A_STATUS: next_st.rdata = {27'h0, output_shutoff, hold_mode,
                                                        dip, permit, st.werr};
                sjd_pkg::SJD_A_IRQST:  next_st.rdata = {29'h0, st.irq_st};
                sjd_pkg::SJD_A_IRQMSK: next_st.rdata = {29'h0, st.irq_msk};
                sjd_pkg::SJD_A_DISP:   next_st.rdata = {16'h0, st.disp};
                sjd_pkg::SJD_A_TARGET: next_st.rdata = {16'h0, st.target};
                default:               next_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            st.term_s1 <= 8'h00;
            st.term_s2 <= 8'h00;
            for (int i = 0; i < 3; i++)
            begin
                st.band[i].point <= sjd_pkg::SJD_DISABLED;
                st.band[i].edge_v <= sjd_pkg::SJD_DISABLED;
            end
            st.mach <= 16'h0000;
            st.poles <= 4'h0;
            st.refspd <= sjd_pkg::SJD_REF_RESET;
            st.regen <= 2'h0;
            st.duty <= 7'h00;
            st.permit_sel <= 3'h0;
            st.dip_sel <= 3'h1;
            st.irq_st <= sjd_pkg::SJD_IRQ_RESET;
            st.irq_msk <= 3'h0;
            st.werr <= 1'b0;
            st.target <= 16'h0000;
            st.disp <= 16'h0000;
            st.rdata <= 32'h0;
            st.permit_prev <= 1'b0;
        end
        else
            st <= next_st;
    end

    always_comb
    begin
        unique case (st.regen)
            2'h1:
                brake_duty_limit = RATING_LARGE ? sjd_pkg::SJD_DUTY_LARGE : st.duty;
            2'h2:
                brake_duty_limit = sjd_pkg::SJD_DUTY_LARGE;
            default:
                brake_duty_limit = RATING_SMALL ? sjd_pkg::SJD_DUTY_SMALL
                                                : sjd_pkg::SJD_DUTY_LARGE;
        endcase
    end

    // converter ready gates the drive output in mode 2
    assign output_shutoff = (st.regen == 2'h2) && !st.term_s2[st.permit_sel];
    assign hold_mode = (st.regen == 2'h2) && retain_mode_on_dip && st.term_s2[st.dip_sel];

    always_comb
    begin
        if (st.mach != 16'h0)
        begin
            speed_unit = sjd_pkg::SJD_UNIT_MACH;
            setting_unit = (st.poles == 4'h0) ? sjd_pkg::SJD_UNIT_RPM : sjd_pkg::SJD_UNIT_MACH;
        end
        else if (st.poles != 4'h0)
        begin
            speed_unit = sjd_pkg::SJD_UNIT_HZ;
            setting_unit = sjd_pkg::SJD_UNIT_HZ;
        end
        else
        begin
            speed_unit = sjd_pkg::SJD_UNIT_RPM;
            setting_unit = sjd_pkg::SJD_UNIT_RPM;
        end
    end

    // target held in whole r/min; frequency entry arrives already as synchronous rpm
    assign target_speed = round_rpm(st.target);
    assign panel_value = st.disp;
    assign write_error = st.werr;
    assign reg_rdata = st.rdata;
    assign irq = |(st.irq_st & st.irq_msk);
endmodule

// ===== sjd_core_asserts.sv
// Purpose: port-level checks of the jump, display and regen block
// Assumes: one clock, nrst synchronous active low
// Notes:   bound to sjd_core from the bench top file
`timescale 1ns/10ps
module sjd_core_asserts #(
    parameter logic RATING_SMALL = 1'b1,
    parameter logic RATING_LARGE = 1'b0
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // register port
    input wire logic [5:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // speed path and drive
    input wire logic [15:0] speed_cmd,
    input wire logic        ramping,
    input wire logic [15:0] target_speed,
    input wire logic        retain_mode_on_dip,
    input wire logic        output_shutoff,
    input wire logic        hold_mode,
    input wire logic [6:0]  brake_duty_limit,
    input wire logic [15:0] panel_value,
    input wire logic        write_error
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // large ratings carry no built-in resistor, so their fixed duty is zero
    localparam logic [6:0] FIXED = (RATING_SMALL && !RATING_LARGE) ?
        sjd_pkg::SJD_DUTY_SMALL : sjd_pkg::SJD_DUTY_LARGE;
    band_off_a:
        assert property ((reg_wr && reg_addr <= 6'h05 && reg_wdata == 32'h0000270F)
            |=> !write_error) else $error("disabling band write refused");
    band_range_a:
        assert property ((reg_wr && reg_addr <= 6'h05 && reg_wdata > 32'h00000E10
            && reg_wdata != 32'h0000270F) |=> write_error) else $error("bad band accepted");
    band_read_a:
        assert property ((reg_wr && reg_addr <= 6'h05 && reg_wdata == 32'h0000270F) ##2
            (reg_rd && reg_addr == $past(reg_addr, 2)) |=> reg_rdata == 32'h0000270F)
            else $error("disabled band reads back wrong");
    duty_fixed_a:
        assert property ((reg_wr && reg_addr == sjd_pkg::SJD_A_REGEN && reg_wdata == 32'h0)
            |=> brake_duty_limit == FIXED) else $error("mode 0 duty not fixed");
    duty_conv_a:
        assert property ((reg_wr && reg_addr == sjd_pkg::SJD_A_REGEN && reg_wdata == 32'h2)
            |=> brake_duty_limit == 7'h00) else $error("converter mode duty not zero");
    shutoff_mode_a:
        assert property ((reg_wr && reg_addr == sjd_pkg::SJD_A_REGEN && reg_wdata < 32'h2)
            |=> !output_shutoff) else $error("shutoff outside converter mode");
    hold_retain_a:
        assert property (!retain_mode_on_dip [*3] |-> !hold_mode)
            else $error("mode held without retain option");
    dash_range_a:
        assert property (panel_value != sjd_pkg::SJD_DASH |-> panel_value <= 16'h270F)
            else $error("panel value above four digits");
    ramp_pass_a:
        assert property ((ramping && speed_cmd % 16'h000A == 16'h0000)
            |=> target_speed == $past(speed_cmd)) else $error("ramping target clamped");
endmodule

// ===== sjd_far_side.sv
// Purpose: converter model feeding the input terminals
// Assumes: permit on terminal 0, dip detect on terminal 1 (reset map)
// Notes:   unmapped terminals float, so they toggle instead of holding a level
`timescale 1ns/10ps
module sjd_far_side (
    // clock
    input wire logic       clk_sys,
    // converter state
    input wire logic       conv_ready,
    input wire logic       conv_dip,
    // terminal pins
    output logic [7:0]     input_terms
);
    logic [5:0] idle_pat = 6'h2A;
    always @(posedge clk_sys)
        idle_pat <= ~idle_pat;
    assign input_terms = {idle_pat, conv_dip, conv_ready};
endmodule

// ===== speed_jump_display_regen_select_test.sv
// Purpose: self-checking bench for the jump, display and regen block
// Assumes: display values derive from running speed in whole r/min
// Notes:   model rounds every target to whole r/min, as the drive holds it
`timescale 1ns/10ps
module speed_jump_display_regen_select_test;
    logic        clk_sys, nrst, reg_wr, reg_rd, ramping, retain_mode_on_dip;
    logic        output_shutoff, hold_mode, write_error, irq, conv_ready, conv_dip;
    logic [5:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] speed_cmd, running_speed, target_speed, panel_value, lfsr;
    logic [7:0]  input_terms;
    logic [6:0]  brake_duty_limit;
    logic [1:0]  speed_unit, setting_unit;
    int          mismatches, comparisons, cycles;
    int          bp [3];
    int          be [3];
    int          dt [5][6] = '{'{0, 0, 1500, 1800, 0, 0}, '{0, 4, 1500, 60, 1, 1},
        '{1000, 0, 1800, 1000, 2, 0}, '{1000, 4, 1800, 1000, 2, 2},
        '{9998, 0, 1, 65535, 2, 0}};
    sjd_core dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .speed_cmd(speed_cmd), .ramping(ramping), .running_speed(running_speed),
        .target_speed(target_speed), .input_terms(input_terms),
        .retain_mode_on_dip(retain_mode_on_dip), .output_shutoff(output_shutoff),
        .hold_mode(hold_mode), .brake_duty_limit(brake_duty_limit),
        .panel_value(panel_value), .speed_unit(speed_unit), .setting_unit(setting_unit),
        .write_error(write_error), .irq(irq));
    sjd_far_side conv (.clk_sys(clk_sys), .conv_ready(conv_ready), .conv_dip(conv_dip),
        .input_terms(input_terms));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    function automatic int mn(int a, int b); return a < b ? a : b; endfunction
    function automatic int mx(int a, int b); return a > b ? a : b; endfunction
    function automatic logic [15:0] nxt(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // model: a band counts only when both ends are set
    function automatic bit band_ok(int k, int v);
        int p [3];
        int e [3];
        p = bp;
        e = be;
        if (k % 2 == 0) p[k / 2] = v; else e[k / 2] = v;
        band_ok = (v <= 3600 || v == 9999);
        for (int i = 0; i < 3; i++)
            for (int j = i + 1; j < 3; j++)
                if (p[i] != 9999 && e[i] != 9999 && p[j] != 9999 && e[j] != 9999
                    && mx(mn(p[i], e[i]), mn(p[j], e[j])) <= mn(mx(p[i], e[i]), mx(p[j], e[j])))
                    band_ok = 0;
    endfunction
    function automatic int jump_exp(int cmd, bit rmp);
        jump_exp = (cmd + 5) / 10 * 10; // settings held in whole r/min
        for (int i = 0; i < 3; i++)
            if (!rmp && bp[i] != 9999 && be[i] != 9999 && cmd >= mn(bp[i], be[i]) * 10
                && cmd <= mx(bp[i], be[i]) * 10)
                jump_exp = bp[i] * 10;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input int d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [5:0] a, input int exp);
        bus(1'b0, a, 0);
        chk(reg_rdata, exp);
    endtask
    task automatic wt;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic wjump(input int k, input int v);
        bit acc;
        acc = band_ok(k, v);
        bus(1'b1, 6'(k), v);
        chk(write_error, !acc);
        if (acc && k % 2 == 0) bp[k / 2] = v;
        if (acc && k % 2 == 1) be[k / 2] = v;
    endtask
    task automatic tgt(input int cmd, input bit rmp);
        @(posedge clk_sys);
        speed_cmd <= 16'(cmd);
        ramping <= rmp;
        wt();
        chk(target_speed, jump_exp(cmd, rmp));
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, speed_cmd, ramping} = '0;
        {retain_mode_on_dip, conv_dip, conv_ready, running_speed} = {3'b001, 16'h4650};
        {mismatches, comparisons, cycles, lfsr} = {32'h0, 32'h0, 32'h0, 16'h808C};
        bp = '{9999, 9999, 9999};
        be = '{9999, 9999, 9999};
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int a = 0; a < 6; a++) rd(6'(a), 9999);
        rd(sjd_pkg::SJD_A_REFSPD, 1500);
        rd(sjd_pkg::SJD_A_INMAP, 32'h100);
        bus(1'b1, 6'h3F, 32'h1234);
        rd(6'h3F, 0);
        wjump(2, 600);
        wjump(3, 700);
        foreach (dt[i]) tgt(5990 + i * 255 - i * 250 + (i == 4 ? 990 : 0), 1'b0);
        tgt(6500, 1'b1);
        wjump(2, 700);
        wjump(3, 600);
        tgt(6000, 1'b0);
        rd(sjd_pkg::SJD_A_TARGET, 7000);
        wjump(0, 650);
        wjump(1, 800);
        wjump(1, 4000);
        rd(6'h01, be[0]);
        chk(irq, 1'b0);
        bus(1'b1, sjd_pkg::SJD_A_IRQMSK, 1);
        wt();
        chk(irq, 1'b1);
        rd(sjd_pkg::SJD_A_IRQST, 1);
        wt();
        chk(irq, 1'b0);
        wjump(0, 9999);
        rd(6'h00, 9999);
        repeat (20)
        begin
            lfsr = nxt(lfsr);
            tgt(lfsr % 3600 * 10, lfsr[0]);
        end
        bus(1'b1, sjd_pkg::SJD_A_DUTY, 10);
        wt();
        chk(brake_duty_limit, sjd_pkg::SJD_DUTY_SMALL);
        bus(1'b1, sjd_pkg::SJD_A_REGEN, 1);
        wt();
        chk(brake_duty_limit, 10);
        bus(1'b1, sjd_pkg::SJD_A_DUTY, 31);
        bus(1'b1, sjd_pkg::SJD_A_DUTY, 30);
        wt();
        chk(brake_duty_limit, sjd_pkg::SJD_DUTY_MAX2);
        bus(1'b1, sjd_pkg::SJD_A_REGEN, 2);
        wt();
        chk({brake_duty_limit, output_shutoff}, 0);
        conv_ready <= 1'b0;
        wt();
        chk(output_shutoff, 1'b1);
        @(posedge clk_sys);
        {conv_ready, conv_dip, retain_mode_on_dip} <= 3'b111;
        wt();
        chk({output_shutoff, hold_mode}, 2'b01);
        @(posedge clk_sys);
        retain_mode_on_dip <= 1'b0;
        wt();
        chk(hold_mode, 1'b0);
        rd(sjd_pkg::SJD_A_IRQST, 6);
        bus(1'b1, sjd_pkg::SJD_A_REGEN, 0);
        wt();
        chk(brake_duty_limit, sjd_pkg::SJD_DUTY_SMALL);
        bus(1'b1, sjd_pkg::SJD_A_REGEN, 3);
        rd(sjd_pkg::SJD_A_REGEN, 0);
        foreach (dt[i])
        begin
            bus(1'b1, sjd_pkg::SJD_A_REFSPD, dt[i][2]);
            bus(1'b1, sjd_pkg::SJD_A_MACH, dt[i][0]);
            bus(1'b1, sjd_pkg::SJD_A_POLES, dt[i][1]);
            wt();
            chk(panel_value, dt[i][3]);
            chk({speed_unit, setting_unit}, dt[i][4] * 4 + dt[i][5]);
        end
        rd(sjd_pkg::SJD_A_DISP, 65535);
        bus(1'b1, sjd_pkg::SJD_A_POLES, 3);
        rd(sjd_pkg::SJD_A_POLES, 0);
        rd(sjd_pkg::SJD_A_STATUS, 6);
        end_of_test();
    end
endmodule
bind sjd_core sjd_core_asserts #(.RATING_SMALL(RATING_SMALL), .RATING_LARGE(RATING_LARGE))
    u_chk (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_cmd(speed_cmd),
    .ramping(ramping), .target_speed(target_speed), .retain_mode_on_dip(retain_mode_on_dip),
    .output_shutoff(output_shutoff), .hold_mode(hold_mode),
    .brake_duty_limit(brake_duty_limit), .panel_value(panel_value),
    .write_error(write_error));
